// *** verilog/fpec_pkg.sv ***
// Package: register map, fields and timing for the flash program/erase control
package fpec_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_OP_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADDR_UPPER = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOWER = 8'h08;
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h18;

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int BIT_START     = 15;
  localparam int BIT_WR_EN     = 14;
  localparam int BIT_ERR       = 13;
  localparam int BIT_IDLE_STOP = 12;
  localparam int OP_MSB        = 3;

  localparam logic [3:0] OP_PAGE_ERASE = 4'h3;
  localparam logic [3:0] OP_DWORD_PROG = 4'h1;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Double-word program needs address bits 1:0 on the odd word boundary
  localparam logic [1:0] DWORD_ALIGN = 2'h2;

  // Interrupt bits: done, error
  localparam int IRQ_W    = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;

  // ------------------------------------------------------------------
  // Timing (25 MHz clock)
  // ------------------------------------------------------------------
  localparam int CLK_MHZ        = 25;
  localparam int ERASE_TIME_US  = 20;
  localparam int PROG_TIME_US   = 2;
  localparam int WAKE_DELAY_US  = 1;
  localparam int ERASE_CYC      = ERASE_TIME_US * CLK_MHZ;
  localparam int PROG_CYC       = PROG_TIME_US * CLK_MHZ;
  localparam int WAKE_CYC       = WAKE_DELAY_US * CLK_MHZ;
  localparam int TMR_W          = 16;

  typedef enum logic [1:0] {
    FPEC_IDLE,
    FPEC_BUSY
  } fpec_state_e;

endpackage

// *** verilog/fpec_op_if.sv ***
// Interface: operation request and completion between control and timer
`timescale 1ns/10ps
`default_nettype none
interface fpec_op_if;
  import fpec_pkg::*;
  logic                 start;
  logic                 erase;
  logic                 done;
  logic                 busy;
  modport ctrl  (output start, output erase, input done, input busy);
  modport timer (input start, input erase, output done, output busy);
endinterface
`default_nettype wire

// *** verilog/fpec_op_timer.sv ***
// Self-timed program/erase cycle counter
`timescale 1ns/10ps
`default_nettype none
module fpec_op_timer
  import fpec_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PROG_CYCLES  = PROG_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Operation handshake
  fpec_op_if.timer  op
);

  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;
  logic             busy_reg;
  logic             busy_next;

  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    if (op.start && !busy_reg) begin
      busy_next = 1'b1;
      cnt_next  = op.erase ? TMR_W'(ERASE_CYCLES - 1)
                           : TMR_W'(PROG_CYCLES - 1);
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign op.busy = busy_reg;
  assign op.done = busy_reg && (cnt_reg == '0);

endmodule
`default_nettype wire

// *** verilog/fpec_top.sv ***
// Flash program/erase control: APB registers, unlock, sequencing, interrupt
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - With idle-stop set the regulator is off in Idle, and flash access waits a wake delay after Idle.
// - Start, write enable, error and operation bits reset only on power-on reset.
// - Double-word program writes two adjacent words on the odd word boundary (address bits 1:0 = 2) in one cycle.
// - The upper address register holds 8 read/write bits in its low byte with undefined reset.
// - The lower address register holds 16 read/write bits with undefined reset.
// - The key register takes 8-bit writes, always reads zero, and defaults to zero.
// - Unimplemented bits read zero and ignore writes.
// - Upper and lower address form one 24-bit target address.
// - The processor is held stalled while an operation is in progress.
module fpec_top
  import fpec_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PROG_CYCLES  = PROG_CYC,
  parameter int WAKE_CYCLES  = WAKE_CYC
) (
  // Clock and resets
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // System
  input  wire logic        cpu_idle,
  output logic             cpu_stall,
  output logic             regulator_on,
  output logic             flash_ready,
  // Flash array
  output logic [23:0]      flash_addr,
  output logic             flash_erase,
  output logic             flash_prog,
  // Interrupt
  output logic             irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  fpec_op_if op ();

  logic             start_reg,  start_next;
  logic             we_reg,     we_next;
  logic             err_reg,    err_next;
  logic             istop_reg,  istop_next;
  logic [OP_MSB:0]  opsel_reg,  opsel_next;
  logic [7:0]       upper_reg,  upper_next;
  logic [15:0]      lower_reg,  lower_next;
  logic [1:0]       key_reg,    key_next;
  logic             unlock_reg, unlock_next;
  logic [IRQ_W-1:0] ists_reg,   ists_next;
  logic [IRQ_W-1:0] ien_reg,    ien_next;
  logic [TMR_W-1:0] wake_reg,   wake_next;
  logic             idle_d_reg;
  logic [31:0]      rdata_reg,  rdata_next;
  fpec_state_e      st_reg,     st_next;

  logic wr_en, rd_en, hit, go_ok, go_bad;
  logic [IRQ_W-1:0] ev;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign hit   = paddr inside {OFS_OP_CONTROL, OFS_ADDR_UPPER,
                               OFS_ADDR_LOWER, OFS_UNLOCK_KEY,
                               OFS_IRQ_STATUS, OFS_IRQ_ENABLE,
                               OFS_IRQ_CLEAR};

  // ------------------------------------------------------------------
  // Start qualification
  // ------------------------------------------------------------------
  logic set_start, op_legal, aligned;
  assign set_start = wr_en && paddr == OFS_OP_CONTROL
                     && pwdata[BIT_START] && !start_reg;
  assign aligned   = lower_reg[1:0] == DWORD_ALIGN;
  assign op_legal  = (pwdata[OP_MSB:0] == OP_PAGE_ERASE)
                     || (pwdata[OP_MSB:0] == OP_DWORD_PROG && aligned);
  // Key must be fresh and write enable set, else flag an error
  assign go_ok  = set_start && pwdata[BIT_WR_EN] && unlock_reg
                  && op_legal && flash_ready;
  assign go_bad = set_start && !go_ok;

  assign op.start = (st_reg == FPEC_IDLE) && go_ok;
  assign op.erase = pwdata[OP_MSB:0] == OP_PAGE_ERASE;
  assign ev[IRQ_DONE] = op.done;
  assign ev[IRQ_ERR]  = go_bad;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    start_next  = start_reg;
    we_next     = we_reg;
    err_next    = err_reg;
    istop_next  = istop_reg;
    opsel_next  = opsel_reg;
    upper_next  = upper_reg;
    lower_next  = lower_reg;
    key_next    = key_reg;
    unlock_next = unlock_reg;
    ien_next    = ien_reg;
    ists_next   = ists_reg;
    st_next     = st_reg;
    rdata_next  = rdata_reg;
    // Any write to another register breaks the back-to-back key pair
    if (wr_en && paddr != OFS_UNLOCK_KEY) begin
      key_next = 2'h0;
    end
    if (wr_en) begin
      case (paddr)
        OFS_OP_CONTROL: begin
          if (st_reg == FPEC_IDLE) begin
            we_next    = pwdata[BIT_WR_EN];
            istop_next = pwdata[BIT_IDLE_STOP];
            opsel_next = pwdata[OP_MSB:0];
            err_next   = pwdata[BIT_ERR];
            start_next = go_ok;
            if (set_start) begin
              unlock_next = 1'b0;
              err_next    = go_bad;
            end
          end
        end
        OFS_ADDR_UPPER: upper_next = pwdata[7:0];
        OFS_ADDR_LOWER: lower_next = pwdata[15:0];
        OFS_UNLOCK_KEY: begin
          unlock_next = 1'b0;
          if (pwdata[7:0] == KEY_FIRST) begin
            key_next = 2'h1;
          end else if (pwdata[7:0] == KEY_SECOND && key_reg == 2'h1) begin
            key_next    = 2'h0;
            unlock_next = 1'b1;
          end else begin
            key_next = 2'h0;
          end
        end
        OFS_IRQ_ENABLE: ien_next = pwdata[IRQ_W-1:0];
        OFS_IRQ_CLEAR:  ists_next = ists_reg & ~pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    ists_next = ists_next | ev; // set wins over clear
    case (st_reg)
      FPEC_IDLE: if (op.start) st_next = FPEC_BUSY;
      FPEC_BUSY: begin
        if (op.done) begin
          st_next    = FPEC_IDLE;
          start_next = 1'b0;
        end
      end
      default: st_next = FPEC_IDLE;
    endcase
    if (rd_en) begin
      case (paddr)
        OFS_OP_CONTROL: rdata_next = {16'h0000, start_reg, we_reg,
                                      err_reg, istop_reg, 8'h00,
                                      opsel_reg};
        OFS_ADDR_UPPER: rdata_next = {24'h000000, upper_reg};
        OFS_ADDR_LOWER: rdata_next = {16'h0000, lower_reg};
        OFS_IRQ_STATUS: rdata_next = {30'h00000000, ists_reg};
        OFS_IRQ_ENABLE: rdata_next = {30'h00000000, ien_reg};
        default:        rdata_next = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Regulator wake delay
  // ------------------------------------------------------------------
  // Regulator only drops when idle-stop is set and nothing is in flight
  assign regulator_on = !(istop_reg && cpu_idle && st_reg == FPEC_IDLE);
  always_comb begin
    wake_next = wake_reg;
    if (!regulator_on) begin
      wake_next = TMR_W'(WAKE_CYCLES);
    end else if (wake_reg != '0) begin
      wake_next = wake_reg - 1'b1;
    end
  end
  assign flash_ready = regulator_on && wake_reg == '0;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Operation bits survive system reset; only power-on clears them
  always_ff @(posedge clock) begin
    if (!por_n) begin
      start_reg <= 1'b0;
      we_reg    <= 1'b0;
      err_reg   <= 1'b0;
      opsel_reg <= '0;
      st_reg    <= FPEC_IDLE;
    end else begin
      start_reg <= start_next;
      we_reg    <= we_next;
      err_reg   <= err_next;
      opsel_reg <= opsel_next;
      st_reg    <= st_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      istop_reg  <= 1'b0;
      key_reg    <= 2'h0;
      unlock_reg <= 1'b0;
      ists_reg   <= '0;
      ien_reg    <= '0;
      wake_reg   <= '0;
      rdata_reg  <= '0;
      idle_d_reg <= 1'b0;
    end else begin
      istop_reg  <= istop_next;
      key_reg    <= key_next;
      unlock_reg <= unlock_next;
      ists_reg   <= ists_next;
      ien_reg    <= ien_next;
      wake_reg   <= wake_next;
      rdata_reg  <= rdata_next;
      idle_d_reg <= cpu_idle;
    end
  end

  // Address registers have no reset value
  always_ff @(posedge clock) begin
    upper_reg <= upper_next;
    lower_reg <= lower_next;
  end

  fpec_op_timer #(
    .ERASE_CYCLES (ERASE_CYCLES),
    .PROG_CYCLES  (PROG_CYCLES)
  ) u_timer (
    .clock (clock),
    .rst_n (por_n),
    .op    (op.timer)
  );

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !hit;
  assign prdata      = rdata_reg;
  assign cpu_stall   = st_reg == FPEC_BUSY;
  assign flash_addr  = {upper_reg, lower_reg};
  assign flash_erase = cpu_stall && opsel_reg == OP_PAGE_ERASE;
  assign flash_prog  = cpu_stall && opsel_reg == OP_DWORD_PROG;
  assign irq         = |(ists_reg & ien_reg);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  AST_START_NEEDS_WE: assert property (@(posedge clock) disable iff (!por_n)
    $rose(cpu_stall) |-> we_reg)
    else $error("operation started without write enable");
  AST_START_CLEARS: assert property (@(posedge clock) disable iff (!por_n)
    $fell(cpu_stall) |-> !start_reg)
    else $error("start bit not cleared at completion");
  AST_STALL_WITH_START: assert property (@(posedge clock) disable iff (!por_n)
    cpu_stall |-> start_reg)
    else $error("stall without running operation");
  AST_ERR_ON_BAD: assert property (@(posedge clock) disable iff (!por_n)
    go_bad && st_reg == FPEC_IDLE |=> err_reg && !cpu_stall)
    else $error("bad start did not flag error");
  AST_NO_ERR_OK: assert property (@(posedge clock) disable iff (!por_n)
    op.start |=> !err_reg)
    else $error("error flag set on good start");
  AST_WAKE_DELAY: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(regulator_on) |-> !flash_ready)
    else $error("flash ready without wake delay");
  AST_REG_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    istop_reg && cpu_idle && !cpu_stall |-> !regulator_on)
    else $error("regulator on in idle with idle-stop");
  AST_KEY_READ_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    rd_en && paddr == OFS_UNLOCK_KEY |=> prdata == 32'h00000000)
    else $error("key register read nonzero");
  AST_CTRL_RSVD: assert property (@(posedge clock) disable iff (!rst_n)
    rd_en && paddr == OFS_OP_CONTROL |=> prdata[11:4] == 8'h00)
    else $error("reserved control bits nonzero");
  // Address has no reset value, so only check after it is written
  AST_ADDR24: assert property (@(posedge clock) disable iff (!rst_n)
    wr_en && paddr == OFS_ADDR_UPPER
      |=> flash_addr[23:16] == $past(pwdata[7:0]))
    else $error("target address upper byte wrong");
  AST_ALIGN: assert property (@(posedge clock) disable iff (!por_n)
    flash_prog |-> flash_addr[1:0] == DWORD_ALIGN)
    else $error("double-word program misaligned");
  COV_ERASE: cover property (@(posedge clock) $rose(flash_erase));
  COV_PROG:  cover property (@(posedge clock) $rose(flash_prog));
  COV_ERR:   cover property (@(posedge clock) $rose(err_reg));
  COV_IRQ:   cover property (@(posedge clock) $rose(irq));
  COV_WAKE:  cover property (@(posedge clock) idle_d_reg && !cpu_idle && istop_reg);

endmodule
`default_nettype wire

// *** verification/fpec_top_tb.sv ***
// Testbench for the flash program/erase control block
`timescale 1ns/10ps
`default_nettype none
module fpec_top_tb;
  import fpec_pkg::*;
  // ------------------------------------------------------------------
  // Signals and instance
  // ------------------------------------------------------------------
  localparam int EC = 8;
  localparam int PC = 4;
  localparam int WC = 3;
  logic        clock    = 1'b0;
  logic        rst_n    = 1'b0;
  logic        por_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        cpu_idle = 1'b0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        cpu_stall;
  logic        regulator_on;
  logic        flash_ready;
  logic [23:0] flash_addr;
  logic        flash_erase;
  logic        flash_prog;
  logic        irq;
  int          n_fail      = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  int          n;
  logic [31:0] d;
  logic        e;

  fpec_top #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC), .WAKE_CYCLES(WC)) u_dut (
    .clock(clock), .rst_n(rst_n), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .cpu_idle(cpu_idle), .cpu_stall(cpu_stall),
    .regulator_on(regulator_on), .flash_ready(flash_ready),
    .flash_addr(flash_addr), .flash_erase(flash_erase),
    .flash_prog(flash_prog), .irq(irq)
  );

  always #20 clock = ~clock;

  // Hang guard, generous against roughly 400 expected cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; an idle edge follows so strobes never toggle twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Wait for the slave; only the hang guard ends a stuck wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, wd, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, exp);
  endtask

  task automatic unlock();
    wr(OFS_UNLOCK_KEY, {24'h0, KEY_FIRST});
    wr(OFS_UNLOCK_KEY, {24'h0, KEY_SECOND});
  endtask

  task automatic wait_done(output int cnt);
    cnt = 0;
    while (cpu_stall === 1'b1 && cnt < 1000) begin
      @(posedge clock);
      cnt++;
    end
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clock);
    rd_chk(OFS_OP_CONTROL, 32'h0);
    rd_chk(OFS_UNLOCK_KEY, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    wr(OFS_ADDR_UPPER, 32'hFFFF_FFA5);
    rd_chk(OFS_ADDR_UPPER, 32'h0000_00A5);
    wr(OFS_ADDR_LOWER, 32'hFFFF_1236);
    rd_chk(OFS_ADDR_LOWER, 32'h0000_1236);
    check({8'h0, flash_addr}, 32'h00A5_1236);
    wr(OFS_UNLOCK_KEY, 32'h0001_FF12);
    rd_chk(OFS_UNLOCK_KEY, 32'h0);
    wr(OFS_OP_CONTROL, 32'h0000_0FF3);
    rd_chk(OFS_OP_CONTROL, 32'h3);
    wr(OFS_IRQ_ENABLE, 32'h3);
    // Page erase, then completion interrupt
    unlock();
    wr(OFS_OP_CONTROL, 32'hC003);
    check({30'h0, cpu_stall, flash_erase}, 32'h3);
    wait_done(n);
    check({31'h0, n >= EC - 1 && n <= EC + 2}, 32'h1);
    rd_chk(OFS_OP_CONTROL, 32'h4003);
    rd_chk(OFS_IRQ_STATUS, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h1);
    check({31'h0, irq}, 32'h0);
    // Double-word program on the aligned boundary
    unlock();
    wr(OFS_OP_CONTROL, 32'hC001);
    check({30'h0, cpu_stall, flash_prog}, 32'h3);
    check({8'h0, flash_addr}, 32'h00A5_1236);
    wait_done(n);
    check({31'h0, n >= PC - 1 && n <= PC + 2}, 32'h1);
    rd_chk(OFS_OP_CONTROL, 32'h4001);
    wr(OFS_IRQ_CLEAR, 32'h1);
    // Misaligned program is refused
    wr(OFS_ADDR_LOWER, 32'h0000_1234);
    unlock();
    wr(OFS_OP_CONTROL, 32'hC001);
    check({31'h0, cpu_stall}, 32'h0);
    rd_chk(OFS_OP_CONTROL, 32'h6001);
    rd_chk(OFS_IRQ_STATUS, 32'h2);
    wr(OFS_IRQ_ENABLE, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h3);
    check({31'h0, irq}, 32'h0);
    wr(OFS_ADDR_LOWER, 32'h0000_1236);
    // Every reserved operation code is refused
    for (int op = 0; op < 16; op++) begin
      if (op != 1 && op != 3) begin
        wr(OFS_OP_CONTROL, 32'h0);
        unlock();
        wr(OFS_OP_CONTROL, 32'hC000 | op);
        check({31'h0, cpu_stall}, 32'h0);
        rd_chk(OFS_OP_CONTROL, 32'h6000 | op);
      end
    end
    // Start without write enable
    wr(OFS_OP_CONTROL, 32'h0);
    unlock();
    wr(OFS_OP_CONTROL, 32'h8003);
    rd_chk(OFS_OP_CONTROL, 32'h2003);
    // Broken key sequence
    wr(OFS_OP_CONTROL, 32'h0);
    wr(OFS_UNLOCK_KEY, {24'h0, KEY_FIRST});
    wr(OFS_UNLOCK_KEY, 32'h11);
    wr(OFS_UNLOCK_KEY, {24'h0, KEY_SECOND});
    wr(OFS_OP_CONTROL, 32'hC003);
    check({31'h0, cpu_stall}, 32'h0);
    rd_chk(OFS_OP_CONTROL, 32'h6003);
    // Idle stop and regulator wake delay
    wr(OFS_OP_CONTROL, 32'h1000);
    rd_chk(OFS_OP_CONTROL, 32'h1000);
    cpu_idle <= 1'b1;
    @(posedge clock);
    check({30'h0, regulator_on, flash_ready}, 32'h0);
    unlock();
    wr(OFS_OP_CONTROL, 32'hD003);
    check({31'h0, cpu_stall}, 32'h0);
    rd_chk(OFS_OP_CONTROL, 32'h7003);
    cpu_idle <= 1'b0;
    @(posedge clock);
    check({30'h0, regulator_on, flash_ready}, 32'h2);
    n = 0;
    while (flash_ready !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, n >= WC - 2 && n <= WC + 1}, 32'h1);
    // System reset alone keeps the power-on bits
    wr(OFS_IRQ_ENABLE, 32'h3);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_chk(OFS_OP_CONTROL, 32'h6003);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    // Unmapped address
    apb(1'b0, 8'h1C, 32'h0, d, e);
    check(d, 32'h0);
    check({31'h0, e}, 32'h1);
    // Power-on reset clears the control register; the address registers are not read back
    rst_n <= 1'b0;
    por_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clock);
    rd_chk(OFS_OP_CONTROL, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
